// ---- rtl/lvm_params.svh ----
`ifndef LVM_PARAMS_SVH
`define LVM_PARAMS_SVH
// register indices on the serial register port
`define LVM_IDX_MONITOR   8'h00
`define LVM_IDX_DELAY     8'h01
`define LVM_IDX_SUPPLY    8'h02
// monitor register fields
`define LVM_MON_RES_MSB   3
`define LVM_MON_MANUAL    4
`define LVM_MON_SHDN      5
`define LVM_MON_EOC       6
// delay register fields
`define LVM_DLY_CODE_MSB  4
`define LVM_DLY_NODELAY   5
// supply register fields
`define LVM_SUP_GEN_EN    0
`define LVM_SUP_GEN_TH    1
`define LVM_SUP_FL_EN     3
`define LVM_SUP_FL_TH     4
// reset values
`define LVM_RST_MONITOR   8'h00
`define LVM_RST_DELAY     8'h00
`define LVM_RST_SUPPLY    8'h00
// timing
`define LVM_CLK_KHZ       10000
`define LVM_STEP_US       250
`define LVM_GEN_DEGL_US   250
`define LVM_FL_DEGL_US    8
`define LVM_STEP_CYC      ((`LVM_STEP_US * `LVM_CLK_KHZ + 999) / 1000)
`define LVM_GEN_DEGL_CYC  ((`LVM_GEN_DEGL_US * `LVM_CLK_KHZ + 999) / 1000)
`define LVM_FL_DEGL_CYC   ((`LVM_FL_DEGL_US * `LVM_CLK_KHZ + 999) / 1000)
`define LVM_CONV_CYC      4
`endif

// ---- rtl/lvm_pkg.sv ----
package lvm_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_CONV = 2'b10
    } conv_state_t;
    typedef logic [3:0] result_t;
endpackage : lvm_pkg

// ---- rtl/step_tick.sv ----
`timescale 1ns/10ps
`default_nettype none
module step_tick #(
    parameter int CYCLES = 2500
) (
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic sys_rst_i,
    // control
    input  wire logic restart_i,
    output logic      tick_o
);
    logic [15:0] cnt_q;

    // free divider, realigned on restart so a step is always whole
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || restart_i || tick_o) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    assign tick_o = (cnt_q == 16'(CYCLES - 1)) && !restart_i;
endmodule : step_tick
`default_nettype wire

// ---- rtl/led_voltage_adc_and_vin_monitor_ctrl.sv ----
// Function
// - the 4-bit result sits in monitor bits 3:0, 0000 below 3.2 V, 0.1 V per code.
// - the converted value is the larger of the two channel codes.
// - a flash pulse start triggers one conversion when the sequencer is idle and not shut down.
// - a write of 1 to monitor bit 4 starts a manual conversion without stopping automatic ones.
// - monitor bit 5 shuts the converter down, no conversion of any kind.
// - monitor bit 6 is a read-only done flag, low while converting.
// - reading the monitor register clears the done flag.
// - the start waits (code+1) x 250 us after the done flag falls.
// - the start delay applies to manual and automatic conversions alike.
// - delay bit 5 starts conversion at once, ignoring the code.
// - supply bit 0 enables the general monitor, bits 2:1 its threshold.
// - supply bit 3 enables the flash monitor, bits 5:4 its threshold.
// - a trip pulses a flag for one cycle and captures the flash code, after 250 us or 8 us.
`timescale 1ns/10ps
`default_nettype none
`include "lvm_params.svh"
module led_voltage_adc_and_vin_monitor_ctrl #(
    parameter int STEP_CYC     = `LVM_STEP_CYC,
    parameter int GEN_DEGL_CYC = `LVM_GEN_DEGL_CYC,
    parameter int FL_DEGL_CYC  = `LVM_FL_DEGL_CYC,
    parameter int CONV_CYC     = `LVM_CONV_CYC
) (
    // clock and reset
    input  wire logic            clk_sys_i,
    input  wire logic            sys_rst_i,
    // register port from the serial front end
    input  wire logic [7:0]      reg_addr_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    input  wire logic [7:0]      reg_wdata_i,
    output logic      [7:0]      reg_rdata_o,
    // flash engine, same clock
    input  wire logic            flash_pulse_i,
    input  wire logic [7:0]      flash_code_i,
    // analog side, asynchronous
    input  wire lvm_pkg::result_t led_channel_one_voltage_i,
    input  wire lvm_pkg::result_t led_channel_two_voltage_i,
    input  wire logic            gen_below_i,
    input  wire logic            flash_below_i,
    // monitor outputs
    output logic      [1:0]      gen_threshold_o,
    output logic      [1:0]      flash_threshold_o,
    output logic                 gen_flag_o,
    output logic                 flash_flag_o,
    output logic      [7:0]      captured_code_o,
    output logic                 converter_on_o
);
    import lvm_pkg::*;
    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [9:0]  sync1_q;
    logic [9:0]  sync2_q;
    result_t     max_code;
    logic        gen_below_s;
    logic        flash_below_s;
    // analog levels pass two flops before use
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sync1_q <= 10'h000;
            sync2_q <= 10'h000;
        end else begin
            sync1_q <= {flash_below_i, gen_below_i,
                        led_channel_two_voltage_i, led_channel_one_voltage_i};
            sync2_q <= sync1_q;
        end
    end
    assign gen_below_s   = sync2_q[8];
    assign flash_below_s = sync2_q[9];
    assign max_code = (sync2_q[7:4] > sync2_q[3:0]) ? sync2_q[7:4] : sync2_q[3:0];
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0]  mon_ctrl_q;     // {shutdown, manual}
    logic [5:0]  delay_q, supply_q;
    logic        eoc_q, wr_mon, rd_mon, shutdown;
    logic        manual_req, flash_q, trigger, conv_done;
    result_t     result_q;
    conv_state_t state_q;
    assign wr_mon   = reg_wr_i && (reg_addr_i == `LVM_IDX_MONITOR);
    assign rd_mon   = reg_rd_i && (reg_addr_i == `LVM_IDX_MONITOR);
    assign shutdown = mon_ctrl_q[1];
    // control registers
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            mon_ctrl_q <= 2'(`LVM_RST_MONITOR >> `LVM_MON_MANUAL);
            delay_q    <= 6'(`LVM_RST_DELAY);
            supply_q   <= 6'(`LVM_RST_SUPPLY);
        end else if (reg_wr_i) begin
            if (wr_mon) begin
                mon_ctrl_q <= reg_wdata_i[`LVM_MON_SHDN:`LVM_MON_MANUAL];
            end
            if (reg_addr_i == `LVM_IDX_DELAY) begin
                delay_q <= reg_wdata_i[5:0];
            end
            if (reg_addr_i == `LVM_IDX_SUPPLY) begin
                supply_q <= reg_wdata_i[5:0];
            end
        end
    end
    // read data is registered; answer one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `LVM_IDX_MONITOR: reg_rdata_o <= {1'b0, eoc_q, mon_ctrl_q, result_q};
                `LVM_IDX_DELAY:   reg_rdata_o <= {2'b00, delay_q};
                `LVM_IDX_SUPPLY:  reg_rdata_o <= {2'b00, supply_q};
                default:          reg_rdata_o <= 8'h00;
            endcase
        end
    end
    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    logic        step_tick_w;
    logic [4:0]  step_cnt_q;
    logic [7:0]  conv_cnt_q;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            flash_q <= 1'b0;
        end else begin
            flash_q <= flash_pulse_i;
        end
    end
    // manual start is a write of bit 4; a write that also shuts down starts nothing
    assign manual_req = wr_mon && reg_wdata_i[`LVM_MON_MANUAL] && !reg_wdata_i[`LVM_MON_SHDN];
    // nothing starts or completes while shut down; busy drops requests
    assign trigger   = (manual_req || (flash_pulse_i && !flash_q))
                       && !shutdown && (state_q == ST_IDLE);
    assign conv_done = (state_q == ST_CONV) && (conv_cnt_q == 8'(CONV_CYC - 1)) && !shutdown;
    assign converter_on_o = !shutdown;
    // step divider restarts at the trigger so the first step is whole
    step_tick #(
        .CYCLES   (STEP_CYC)
    ) u_step (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .restart_i (trigger),
        .tick_o    (step_tick_w)
    );
    // one sequencer serves both trigger sources
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || shutdown) begin
            state_q <= ST_IDLE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (trigger) begin
                        state_q <= delay_q[`LVM_DLY_NODELAY] ? ST_CONV : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (step_tick_w && step_cnt_q == delay_q[`LVM_DLY_CODE_MSB:0]) begin
                        state_q <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (conv_done) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
    // step and conversion counters
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state_q == ST_IDLE) begin
            step_cnt_q <= 5'h00;
            conv_cnt_q <= 8'h00;
        end else begin
            if (state_q == ST_WAIT && step_tick_w) begin
                step_cnt_q <= step_cnt_q + 5'h01;
            end
            if (state_q == ST_CONV) begin
                conv_cnt_q <= conv_cnt_q + 8'h01;
            end
        end
    end
    // done flag: falls at start, rises at completion
    // read clears it, but a completion in that cycle wins
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            eoc_q <= 1'b0;
        end else if (conv_done) begin
            eoc_q <= 1'b1;
        end else if (trigger || rd_mon) begin
            eoc_q <= 1'b0;
        end
    end
    // result loads only with the done flag
    // code is the banded level, 0000 below the lowest band
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            result_q <= 4'h0;
        end else if (conv_done) begin
            result_q <= max_code;
        end
    end
    // ------------------------------------------------------------
    // supply monitors
    // ------------------------------------------------------------
    logic [11:0] gen_cnt_q, fl_cnt_q;
    logic        gen_arm, fl_arm;
    assign gen_threshold_o   = supply_q[`LVM_SUP_GEN_TH +: 2];
    assign gen_arm           = supply_q[`LVM_SUP_GEN_EN] && gen_below_s;
    // flash monitor only counts during a flash
    assign flash_threshold_o = supply_q[`LVM_SUP_FL_TH +: 2];
    assign fl_arm            = supply_q[`LVM_SUP_FL_EN] && flash_below_s && flash_pulse_i;
    // deglitch counters; the flag fires once per crossing
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !gen_arm) begin
            gen_cnt_q <= 12'h000;
        end else if (gen_cnt_q != 12'(GEN_DEGL_CYC)) begin
            gen_cnt_q <= gen_cnt_q + 12'h001;
        end
    end
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || !fl_arm) begin
            fl_cnt_q <= 12'h000;
        end else if (fl_cnt_q != 12'(FL_DEGL_CYC)) begin
            fl_cnt_q <= fl_cnt_q + 12'h001;
        end
    end
    assign gen_flag_o   = gen_arm && (gen_cnt_q == 12'(GEN_DEGL_CYC - 1));
    assign flash_flag_o = fl_arm && (fl_cnt_q == 12'(FL_DEGL_CYC - 1));
    // capture the flash code with the flag
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            captured_code_o <= 8'h00;
        end else if (gen_flag_o || flash_flag_o) begin
            captured_code_o <= flash_code_i;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    int wait_cyc_q;
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i || state_q != ST_WAIT) begin
            wait_cyc_q <= 0;
        end else begin
            wait_cyc_q <= wait_cyc_q + 1;
        end
    end
    property p_result_hold;
        !$stable(result_q) |-> $rose(eoc_q);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result moved without done");
    property p_shutdown;
        shutdown |=> state_q == ST_IDLE && $stable(result_q);
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("converter ran while shut down");
    property p_flash_start;
        (flash_pulse_i && !flash_q && !shutdown && state_q == ST_IDLE) |=> state_q != ST_IDLE && !eoc_q;
    endproperty
    a_flash_start: assert property (p_flash_start) else $error("flash did not start conversion");
    property p_read_clear;
        (rd_mon && !conv_done) |=> !eoc_q;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read left done flag set");
    property p_nodelay;
        (trigger && delay_q[`LVM_DLY_NODELAY]) |=> state_q == ST_CONV;
    endproperty
    a_nodelay: assert property (p_nodelay) else $error("no-delay start was late");
    property p_max_code;
        conv_done |=> result_q == $past(max_code) && eoc_q;
    endproperty
    a_max_code: assert property (p_max_code) else $error("result is not the higher channel");
    property p_delay_len;
        (state_q == ST_WAIT) ##1 (state_q == ST_CONV)
            |-> $past(wait_cyc_q) + 1 == (int'(delay_q[4:0]) + 1) * STEP_CYC;
    endproperty
    a_delay_len: assert property (p_delay_len) else $error("start delay length wrong");
    property p_capture;
        gen_flag_o |=> captured_code_o == $past(flash_code_i);
    endproperty
    a_capture: assert property (p_capture) else $error("flash code not captured");
    c_conv_done:  cover property (conv_done);
    c_read_clear: cover property (eoc_q && rd_mon);
    c_gen_trip:   cover property (gen_flag_o);
    c_fl_trip:    cover property (flash_flag_o);
endmodule : led_voltage_adc_and_vin_monitor_ctrl
`default_nettype wire

// ---- dv/lvm_host.sv ----
`timescale 1ns/10ps
`default_nettype none
// host software model on the register port, drives on the falling edge
module lvm_host (
    // clock
    input  wire logic       clk_sys_i,
    // register port
    output logic      [7:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i
);
    // idle port
    initial begin
        reg_addr_o  = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end
    // one write; data inverted after so stale bytes never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(negedge clk_sys_i);
        reg_wr_o    = 1'b0;
        reg_wdata_o = ~d;
    endtask : wr
    // one read, data taken the cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_i);
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(negedge clk_sys_i);
        reg_rd_o = 1'b0;
        d        = reg_rdata_i;
    endtask : rd
endmodule : lvm_host
`default_nettype wire

// ---- dv/led_voltage_adc_and_vin_monitor_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module led_voltage_adc_and_vin_monitor_ctrl_bench;
    import lvm_pkg::*;
    localparam int STEP = 4;
    localparam int CONV = 4;
    logic       clk_sys_i, sys_rst_i, flash_pulse_i, gen_below_i, flash_below_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, flash_code_i, captured_code_o;
    logic       reg_wr_i, reg_rd_i, gen_flag_o, flash_flag_o, converter_on_o;
    logic [1:0] gen_threshold_o, flash_threshold_o;
    result_t    ch1, ch2;
    logic [7:0] d, mon;
    int         bad_count, checks_done, n, res;
    int         exp_q[$];
    // -------------------------------------------------------------
    // design and host
    // -------------------------------------------------------------
    led_voltage_adc_and_vin_monitor_ctrl #(.STEP_CYC(STEP), .GEN_DEGL_CYC(5),
        .FL_DEGL_CYC(3), .CONV_CYC(CONV)) i_led_voltage_adc_and_vin_monitor_ctrl (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .flash_pulse_i(flash_pulse_i),
        .flash_code_i(flash_code_i), .led_channel_one_voltage_i(ch1),
        .led_channel_two_voltage_i(ch2), .gen_below_i(gen_below_i),
        .flash_below_i(flash_below_i), .gen_threshold_o(gen_threshold_o),
        .flash_threshold_o(flash_threshold_o), .gen_flag_o(gen_flag_o),
        .flash_flag_o(flash_flag_o), .captured_code_o(captured_code_o),
        .converter_on_o(converter_on_o));
    lvm_host i_lvm_host (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i),
        .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .reg_wdata_o(reg_wdata_i),
        .reg_rdata_i(reg_rdata_o));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop
    // one conversion; manual trigger by write, automatic by flash edge
    task automatic conv(input int code, input bit nd, input bit au);
        int w;
        ch1 = result_t'($urandom_range(15));
        ch2 = result_t'($urandom_range(15));
        // model: the higher channel becomes the next result
        exp_q.push_back((ch1 > ch2) ? int'(ch1) : int'(ch2));
        i_lvm_host.wr(8'h01, {2'b00, nd, code[4:0]});
        i_lvm_host.rd(8'h01, d);
        chk(d, {2'b00, nd, code[4:0]});
        repeat (4) @(negedge clk_sys_i);
        w = nd ? 0 : (code + 1) * STEP;
        if (au) begin
            flash_pulse_i = 1'b1;
        end else begin
            i_lvm_host.wr(8'h00, 8'h10);
        end
        if (w > 0) begin
            repeat (w - 2) @(negedge clk_sys_i);
            i_lvm_host.rd(8'h00, d);
            chk(d, {4'h1, 4'(res)});
        end
        repeat (CONV + 4) @(negedge clk_sys_i);
        flash_pulse_i = 1'b0;
        res = exp_q.pop_front();
        i_lvm_host.rd(8'h00, d);
        chk(d, {4'h5, 4'(res)});
        i_lvm_host.rd(8'h00, d);
        chk(d, {4'h1, 4'(res)});
        $display("conversion code %0d nodelay %0d auto %0d done", code, nd, au);
    endtask : conv
    // one supply crossing, flag pulse then captured flash code
    task automatic trip(input bit fl, input bit en);
        int k;
        flash_code_i  = 8'($urandom);
        flash_pulse_i = fl;
        flash_below_i = fl;
        gen_below_i   = !fl;
        for (k = 0; k < 20; k++) begin
            @(negedge clk_sys_i);
            if ((fl ? flash_flag_o : gen_flag_o) === 1'b1) break;
        end
        chk(8'(k < 20), 8'(en));
        @(negedge clk_sys_i);
        if (en) chk(captured_code_o, flash_code_i);
        {gen_below_i, flash_below_i, flash_pulse_i} = 3'b000;
        repeat (4) @(negedge clk_sys_i);
        $display("trip flash %0d enabled %0d done", fl, en);
    endtask : trip
    // -------------------------------------------------------------
    // clock, watchdog, sequence
    // -------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // far above the few hundred cycles the tests take
    initial begin
        #(30000 * 100);
        bad_count++;
        report_and_stop();
    end
    initial begin
        {sys_rst_i, flash_pulse_i, gen_below_i, flash_below_i} = 4'b1000;
        {ch1, ch2, flash_code_i} = 16'h0000;
        bad_count   = 0;
        checks_done = 0;
        res         = 0;
        n = $urandom(65815);
        repeat (4) @(negedge clk_sys_i);
        sys_rst_i = 1'b0;
        // reset values, unmapped index, read-only bits
        for (int a = 0; a < 4; a++) begin
            i_lvm_host.wr(8'(a + 4), 8'hff);
            i_lvm_host.rd(8'(a), d);
            chk(d, 8'h00);
        end
        chk(8'(converter_on_o), 8'h01);
        i_lvm_host.wr(8'h00, 8'hcf);
        i_lvm_host.rd(8'h00, d);
        chk(d, 8'h00);
        // supply settings and threshold outputs
        mon = 8'($urandom_range(63));
        i_lvm_host.wr(8'h02, mon);
        i_lvm_host.rd(8'h02, d);
        chk(d, mon);
        chk(8'({gen_threshold_o, flash_threshold_o}), 8'({mon[2:1], mon[5:4]}));
        $display("register test done");
        conv(0, 1, 0);
        conv(0, 0, 0);
        conv(31, 0, 1);
        conv($urandom_range(31), 0, 1);
        conv($urandom_range(31), 1, 1);
        i_lvm_host.wr(8'h00, 8'h30);
        chk(8'(converter_on_o), 8'h00);
        flash_pulse_i = 1'b1;
        repeat (150) @(negedge clk_sys_i);
        flash_pulse_i = 1'b0;
        i_lvm_host.rd(8'h00, d);
        chk(d, {4'h3, 4'(res)});
        i_lvm_host.wr(8'h00, 8'h00);
        $display("shutdown test done");
        i_lvm_host.wr(8'h02, 8'h09);
        trip(0, 1);
        trip(1, 1);
        i_lvm_host.wr(8'h02, 8'h00);
        trip(0, 0);
        trip(1, 0);
        report_and_stop();
    end
endmodule : led_voltage_adc_and_vin_monitor_ctrl_bench
`default_nettype wire
